/* tsg_ahb_host.sv */
// AHB-Lite host model issuing single-word register transfers
`timescale 1ns/1ns
module tsg_ahb_host (
	input wire logic sys_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [15:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata,
	output logic hung
);
	initial begin
		hsel = 1'b0;
		haddr = 16'h0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		hung = 1'b0;
	end
	// a stuck slave raises hung rather than hanging the run
	task automatic waitReady();
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (hready === 1'b1)
				break;
		end
		if (n == 20)
			hung = 1'b1;
	endtask
	task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {idx, 2'b00};
		htrans <= 2'h2;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		waitReady();
		rd = hrdata;
	endtask
endmodule

/* tsg_config_block.sv */
// trackpad sensing configuration registers with acquisition sequencer, position processing and gesture gate
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`include "tsg_regs.svh"
module tsg_config_block
	import tsg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [15:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire tsg_mode_t powerMode,
	input wire logic convStart,
	input wire logic senseEdge,
	input wire tsg_pos_t rawPos,
	input wire logic areaOk,
	input wire logic [15:0] gestureDetect,
	output logic convActive_r,
	output logic convWake_r,
	output tsg_freq_t convFreq_r,
	output logic [11:0] convCount_r,
	output logic convDone_r,
	output tsg_pos_t outPos_r,
	output logic [15:0] gestureOut_r,
	output logic irq_r
);

	// ****************************************
	// decoding helpers
	// ****************************************
	function automatic logic [11:0] delayCycles(input logic [1:0] code);
		case (code)
			2'h0: delayCycles = `TSG_DELAY_C0;
			2'h1: delayCycles = `TSG_DELAY_C1;
			2'h2: delayCycles = `TSG_DELAY_C2;
			default: delayCycles = `TSG_DELAY_C3;
		endcase
	endfunction

	// codes above 100 are undefined; they saturate at the largest limit
	function automatic logic [11:0] countLimit(input logic [2:0] code);
		case (code)
			3'h0: countLimit = `TSG_LIMIT_C0;
			3'h1: countLimit = `TSG_LIMIT_C1;
			3'h2: countLimit = `TSG_LIMIT_C2;
			3'h3: countLimit = `TSG_LIMIT_C3;
			default: countLimit = `TSG_LIMIT_C4;
		endcase
	endfunction

	function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
		absDiff = (a > b) ? a - b : b - a;
	endfunction

	// ****************************************
	// register storage
	// ****************************************
	tsg_freq_t padFreq_r, wakeFreq_r;
	logic [15:0] padAcq_r, wakeAcq_r, gestEn_r;
	logic [7:0] posCfg_r;
	logic wakeEnable_r;
	logic [2:0] irqStat_r, irqMask_r;

	logic dataWrite_r;
	logic [13:0] dataIdx_r;
	logic addrTaken;
	logic [13:0] addrIdx;
	logic [31:0] readMux;
	logic statRead;
	logic [2:0] irqEvents;

	assign addrTaken = hsel && hready && htrans[1];
	assign addrIdx = haddr[15:2];
	assign statRead = addrTaken && !hwrite && (addrIdx == `TSG_IDX_IRQ_STAT);

	// ****************************************
	// bus slave
	// ****************************************
	// zero-wait slave: every transfer completes in one data phase, always OKAY
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dataWrite_r <= 1'b0;
			dataIdx_r <= 14'h0000;
		end else if (hready) begin
			dataWrite_r <= addrTaken && hwrite;
			dataIdx_r <= addrIdx;
		end
	end

	always_comb begin
		readMux = 32'h00000000;
		case (addrIdx)
			`TSG_IDX_PAD_FRAC: readMux[7:0] = padFreq_r.fraction;
			`TSG_IDX_PAD_P1: readMux[7:0] = padFreq_r.periodOne;
			`TSG_IDX_PAD_P2: readMux[7:0] = padFreq_r.periodTwo;
			`TSG_IDX_WAKE_FRAC: readMux[7:0] = wakeFreq_r.fraction;
			`TSG_IDX_WAKE_P1: readMux[7:0] = wakeFreq_r.periodOne;
			`TSG_IDX_WAKE_P2: readMux[7:0] = wakeFreq_r.periodTwo;
			`TSG_IDX_PAD_ACQ: readMux[15:0] = padAcq_r;
			`TSG_IDX_WAKE_ACQ: readMux[15:0] = wakeAcq_r;
			`TSG_IDX_POS: readMux[7:0] = posCfg_r;
			`TSG_IDX_GEST: readMux[15:0] = gestEn_r;
			`TSG_IDX_CTRL: readMux[0] = wakeEnable_r;
			`TSG_IDX_IRQ_STAT: readMux[2:0] = irqStat_r;
			`TSG_IDX_IRQ_MASK: readMux[2:0] = irqMask_r;
			default: readMux = 32'h00000000;
		endcase
	end

	// read data is captured at the address phase and stands through the data phase
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h00000000;
		end else if (addrTaken && !hwrite) begin
			hrdata <= readMux;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			padFreq_r <= {3{`TSG_RST_BYTE}};
			wakeFreq_r <= {3{`TSG_RST_BYTE}};
		end else if (dataWrite_r) begin
			case (dataIdx_r)
				`TSG_IDX_PAD_FRAC: padFreq_r.fraction <= hwdata[7:0];
				`TSG_IDX_PAD_P1: padFreq_r.periodOne <= hwdata[7:0];
				`TSG_IDX_PAD_P2: padFreq_r.periodTwo <= hwdata[7:0];
				`TSG_IDX_WAKE_FRAC: wakeFreq_r.fraction <= hwdata[7:0];
				`TSG_IDX_WAKE_P1: wakeFreq_r.periodOne <= hwdata[7:0];
				`TSG_IDX_WAKE_P2: wakeFreq_r.periodTwo <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// separate trackpad and wake acquisition words
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			padAcq_r <= `TSG_RST_WORD;
			wakeAcq_r <= `TSG_RST_WORD;
			posCfg_r <= `TSG_RST_POS;
			gestEn_r <= `TSG_RST_WORD;
			wakeEnable_r <= 1'b0;
			irqMask_r <= 3'h0;
		end else if (dataWrite_r) begin
			case (dataIdx_r)
				`TSG_IDX_PAD_ACQ: padAcq_r <= hwdata[15:0];
				`TSG_IDX_WAKE_ACQ: wakeAcq_r <= hwdata[15:0];
				`TSG_IDX_POS: posCfg_r <= hwdata[7:0] & `TSG_POS_MASK;
				// unused gesture bits 7-5 stay zero
				`TSG_IDX_GEST: gestEn_r <= hwdata[15:0] & `TSG_GEST_MASK;
				`TSG_IDX_CTRL: wakeEnable_r <= hwdata[0];
				`TSG_IDX_IRQ_MASK: irqMask_r <= hwdata[2:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// interrupt
	// ****************************************
	// a new event in the clearing read's cycle survives the clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irqStat_r <= 3'h0;
		end else begin
			irqStat_r <= (statRead ? 3'h0 : irqStat_r) | irqEvents;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irqStat_r & irqMask_r);
		end
	end

	// ****************************************
	// acquisition sequencer
	// ****************************************
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_COUNT} tsg_seq_t;
	tsg_seq_t seqState_r;
	logic [11:0] seqTimer_r, seqLimit_r;
	logic useWake;
	logic [15:0] activeAcq;

	// wake channel replaces the trackpad in either low-power mode
	assign useWake = wakeEnable_r && (powerMode != TSG_MODE_ACTIVE);
	assign activeAcq = useWake ? wakeAcq_r : padAcq_r;

	// settings are latched at start so a write mid-conversion cannot disturb it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			seqState_r <= SEQ_IDLE;
			seqTimer_r <= 12'h000;
			seqLimit_r <= 12'h000;
			convCount_r <= 12'h000;
			convActive_r <= 1'b0;
			convWake_r <= 1'b0;
			convFreq_r <= {3{`TSG_RST_BYTE}};
			convDone_r <= 1'b0;
		end else begin
			convDone_r <= 1'b0;
			case (seqState_r)
				SEQ_IDLE: begin
					if (convStart) begin
						seqTimer_r <= delayCycles(activeAcq[`TSG_ACQ_DELAY_HI:`TSG_ACQ_DELAY_LO]);
						seqLimit_r <= countLimit(activeAcq[`TSG_ACQ_LIMIT_HI:`TSG_ACQ_LIMIT_LO]);
						convWake_r <= useWake;
						convFreq_r <= useWake ? wakeFreq_r : padFreq_r;
						convCount_r <= 12'h000;
						convActive_r <= 1'b1;
						seqState_r <= SEQ_DELAY;
					end
				end
				SEQ_DELAY: begin
					seqTimer_r <= seqTimer_r - 12'h001;
					if (seqTimer_r == 12'h001) begin
						seqState_r <= SEQ_COUNT;
					end
				end
				SEQ_COUNT: begin
					if (convCount_r == seqLimit_r) begin
						convActive_r <= 1'b0;
						convDone_r <= 1'b1;
						seqState_r <= SEQ_IDLE;
					end else if (senseEdge) begin
						convCount_r <= convCount_r + 12'h001;
					end
				end
				default: seqState_r <= SEQ_IDLE;
			endcase
		end
	end

	// ****************************************
	// position processing
	// ****************************************
	tsg_pos_t mapped_r;
	logic [15:0] jitX, jitY, nxtX, nxtY, moveX, moveY;
	logic [3:0] dampShift;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mapped_r <= '0;
		end else begin
			// area filter drops failing samples unless bypassed
			mapped_r.valid <= rawPos.valid && (areaOk || posCfg_r[`TSG_POS_AREA_BYP]);
			mapped_r.x <= (posCfg_r[`TSG_POS_AXIS_EXCH] ? rawPos.y : rawPos.x)
				^ {16{posCfg_r[`TSG_POS_FLIP_X]}};
			mapped_r.y <= (posCfg_r[`TSG_POS_AXIS_EXCH] ? rawPos.x : rawPos.y)
				^ {16{posCfg_r[`TSG_POS_FLIP_Y]}};
		end
	end

	always_comb begin
		moveX = absDiff(mapped_r.x, outPos_r.x);
		moveY = absDiff(mapped_r.y, outPos_r.y);
		// small moves are held as jitter
		jitX = (posCfg_r[`TSG_POS_JITTER] && moveX < `TSG_JITTER_BAND) ? outPos_r.x : mapped_r.x;
		jitY = (posCfg_r[`TSG_POS_JITTER] && moveY < `TSG_JITTER_BAND) ? outPos_r.y : mapped_r.y;
		// fast moves get lighter damping unless damping is fixed
		dampShift = (!posCfg_r[`TSG_POS_FIXED_DAMP] && (moveX > `TSG_IIR_MOVE || moveY > `TSG_IIR_MOVE))
			? 4'h1 : 4'h2;
		// IIR step toward the new sample
		if (posCfg_r[`TSG_POS_IIR]) begin
			nxtX = (jitX >= outPos_r.x) ? outPos_r.x + ((jitX - outPos_r.x) >> dampShift)
				: outPos_r.x - ((outPos_r.x - jitX) >> dampShift);
			nxtY = (jitY >= outPos_r.y) ? outPos_r.y + ((jitY - outPos_r.y) >> dampShift)
				: outPos_r.y - ((outPos_r.y - jitY) >> dampShift);
		end else begin
			nxtX = jitX;
			nxtY = jitY;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			outPos_r <= '0;
		end else begin
			outPos_r.valid <= mapped_r.valid;
			if (mapped_r.valid) begin
				outPos_r.x <= nxtX;
				outPos_r.y <= nxtY;
			end
		end
	end

	// ****************************************
	// gesture gate
	// ****************************************
	// each detection passes only with its enable
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gestureOut_r <= 16'h0000;
		end else begin
			gestureOut_r <= gestureDetect & gestEn_r;
		end
	end

	assign irqEvents = {|(gestureDetect & gestEn_r), mapped_r.valid, convDone_r};

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence convBegin;
		seqState_r == SEQ_IDLE && convStart;
	endsequence

	wake_select_a: assert property (convBegin |=> convWake_r == $past(useWake))
		else $error("wake channel selection wrong");
	freq_select_a: assert property (convBegin |=> convFreq_r == (convWake_r ? wakeFreq_r : padFreq_r))
		else $error("conversion frequency bytes wrong");
	// expected count spelled out from the constants, not through the decoder it guards
	delay_load_a: assert property (convBegin |=> seqTimer_r ==
		(($past(activeAcq[`TSG_ACQ_DELAY_HI:`TSG_ACQ_DELAY_LO]) == 2'h0) ? `TSG_DELAY_C0
		: ($past(activeAcq[`TSG_ACQ_DELAY_HI:`TSG_ACQ_DELAY_LO]) == 2'h1) ? `TSG_DELAY_C1
		: ($past(activeAcq[`TSG_ACQ_DELAY_HI:`TSG_ACQ_DELAY_LO]) == 2'h2) ? `TSG_DELAY_C2
		: `TSG_DELAY_C3))
		else $error("initial delay count wrong");
	// timer loaded with 16 is seen one edge after the start; the count state shows sixteen edges later
	delay_short_a: assert property (convBegin ##1 (seqTimer_r == 12'h010) |-> ##16 seqState_r == SEQ_COUNT)
		else $error("sixteen cycle delay not honoured");
	limit_stop_a: assert property (seqState_r == SEQ_COUNT && convCount_r == seqLimit_r
		|=> convDone_r && !convActive_r)
		else $error("conversion not halted at limit");
	limit_bound_a: assert property (convActive_r |-> convCount_r <= seqLimit_r)
		else $error("count ran past its limit");
	acq_split_a: assert property (dataWrite_r && dataIdx_r == `TSG_IDX_WAKE_ACQ |=> $stable(padAcq_r))
		else $error("wake write disturbed trackpad settings");
	area_drop_a: assert property (rawPos.valid && !areaOk && !posCfg_r[`TSG_POS_AREA_BYP]
		|=> !mapped_r.valid)
		else $error("area filter let sample through");
	flip_x_a: assert property (posCfg_r[`TSG_POS_FLIP_X] && !posCfg_r[`TSG_POS_AXIS_EXCH] && $stable(posCfg_r)
		|=> mapped_r.x == ~$past(rawPos.x))
		else $error("x not inverted");
	axis_swap_a: assert property (posCfg_r[`TSG_POS_AXIS_EXCH] && posCfg_r[1:0] == 2'h0 && $stable(posCfg_r)
		|=> mapped_r.x == $past(rawPos.y))
		else $error("axes not exchanged");
	gesture_gate_a: assert property (1'b1 |=> gestureOut_r == ($past(gestureDetect) & $past(gestEn_r)))
		else $error("disabled gesture reported");
	irq_level_a: assert property (|(irqStat_r & irqMask_r) |=> irq_r)
		else $error("interrupt not raised");

endmodule

/* tsg_config_block_tb.sv */
// self-checking bench for the trackpad config block
`timescale 1ns/1ns
`include "tsg_regs.svh"
module tsg_config_block_tb
	import tsg_pkg::*;
;
	logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, hung, convStart, senseEdge, areaOk;
	logic convActive_r, convWake_r, convDone_r, irq_r;
	logic [15:0] haddr, gestureDetect, gestureOut_r;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata;
	logic [11:0] convCount_r;
	tsg_mode_t powerMode;
	tsg_pos_t rawPos, outPos_r;
	tsg_freq_t convFreq_r;
	int nErrors, samplesChecked;

	tsg_config_block uut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .powerMode(powerMode), .convStart(convStart), .senseEdge(senseEdge), .rawPos(rawPos),
		.areaOk(areaOk), .gestureDetect(gestureDetect), .convActive_r(convActive_r), .convWake_r(convWake_r),
		.convFreq_r(convFreq_r), .convCount_r(convCount_r), .convDone_r(convDone_r), .outPos_r(outPos_r),
		.gestureOut_r(gestureOut_r), .irq_r(irq_r));
	tsg_ahb_host host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hung(hung));

	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [13:0] idx, input logic [31:0] d);
		logic [31:0] x;
		host.xfer(1'b1, idx, d, x);
	endtask
	task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] x;
		host.xfer(1'b0, idx, 32'h0, x);
		chk(x, exp, what);
	endtask
	task automatic conclude();
		if (hung === 1'b1)
			nErrors++;
		$display("checks %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic testRegs();
		logic [13:0] idx [10];
		logic [31:0] msk [10];
		idx = '{`TSG_IDX_PAD_FRAC, `TSG_IDX_PAD_P1, `TSG_IDX_PAD_P2, `TSG_IDX_WAKE_FRAC, `TSG_IDX_WAKE_P1,
			`TSG_IDX_WAKE_P2, `TSG_IDX_PAD_ACQ, `TSG_IDX_WAKE_ACQ, `TSG_IDX_POS, `TSG_IDX_GEST};
		msk = '{32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFFFF, 32'hFFFF, 32'h7F, 32'hFF1F};
		for (int i = 0; i < 10; i++)
			rdc(idx[i], (i == 8) ? 32'h08 : 32'h0, "reset value");
		// distinct values catch aliased registers; low bytes set the reserved bits too
		for (int i = 0; i < 10; i++)
			wr(idx[i], 32'hA5C3_96E0 + i);
		for (int i = 0; i < 10; i++)
			rdc(idx[i], (32'hA5C3_96E0 + i) & msk[i], "readback");
		wr(14'h1100, 32'hFFFF_FFFF);
		rdc(14'h1100, 32'h0, "unmapped");
		chk({31'h0, hresp}, 32'h0, "okay response");
	endtask

	task automatic testConv();
		int lim [5] = '{383, 511, 767, 1023, 2047};
		int dly [4] = '{16, 32, 64, 256};
		int base, t;
		logic wake;
		// pad at 1.00 MHz, wake channel at 4.00 MHz
		wr(`TSG_IDX_PAD_FRAC, 32'h10);
		wr(`TSG_IDX_PAD_P1, 32'h07);
		wr(`TSG_IDX_PAD_P2, 32'h07);
		wr(`TSG_IDX_WAKE_FRAC, 32'h40);
		wr(`TSG_IDX_WAKE_P1, 32'h01);
		wr(`TSG_IDX_WAKE_P2, 32'h01);
		for (int i = 0; i < 5; i++) begin
			wake = (i == 1 || i == 3);
			wr(`TSG_IDX_IRQ_MASK, {31'h0, i != 4});
			wr(`TSG_IDX_CTRL, {31'h0, wake});
			wr(wake ? `TSG_IDX_WAKE_ACQ : `TSG_IDX_PAD_ACQ, {16'h0, i[1:0], 3'h0, i[2:0], 8'h00});
			@(posedge sys_clk);
			powerMode <= (i == 0) ? TSG_MODE_ACTIVE : ((i == 1 || i == 4) ? TSG_MODE_LOW_ONE : TSG_MODE_LOW_TWO);
			senseEdge <= 1'b1;
			convStart <= 1'b1;
			@(posedge sys_clk);
			convStart <= 1'b0;
			for (t = 1; t < 400 && convCount_r !== 12'h001; t++)
				@(posedge sys_clk);
			// delay measured against the 16-cycle code, so fixed pipeline offsets cancel
			if (i == 0)
				base = t;
			chk(t - base, dly[i % 4] - 16, "initial delay");
			chk({31'h0, convActive_r}, 32'h1, "active while counting");
			for (t = 0; t < 2100 && convDone_r !== 1'b1; t++)
				@(posedge sys_clk);
			chk(convCount_r, lim[i], "count limit");
			chk({31'h0, convActive_r}, 32'h0, "halted at limit");
			chk({31'h0, convWake_r}, {31'h0, wake}, "channel choice");
			chk(convFreq_r, wake ? 32'h0040_0101 : 32'h0010_0707, "frequency bytes");
			senseEdge <= 1'b0;
			repeat (3) @(posedge sys_clk);
			chk({31'h0, irq_r}, {31'h0, i != 4}, "irq level");
			rdc(`TSG_IDX_IRQ_STAT, 32'h1, "done status");
			repeat (3) @(posedge sys_clk);
			chk({31'h0, irq_r}, 32'h0, "irq cleared");
		end
	endtask

	task automatic posSample(input logic [7:0] cfg, input logic ok, input logic [31:0] raw, output logic seen,
		output logic [31:0] xy);
		wr(`TSG_IDX_POS, {24'h0, cfg});
		@(posedge sys_clk);
		rawPos <= {1'b1, raw};
		areaOk <= ok;
		@(posedge sys_clk);
		rawPos <= {1'b0, raw};
		seen = 1'b0;
		for (int n = 0; n < 5 && !seen; n++) begin
			@(posedge sys_clk);
			seen = (outPos_r.valid === 1'b1);
			xy = {outPos_r.x, outPos_r.y};
		end
	endtask

	task automatic testPos();
		logic seen;
		logic [31:0] xy, exp;
		// filters off so only exchange and inversion shape the output
		for (int s = 0; s < 8; s++) begin
			posSample(8'h40 | s[7:0], 1'b0, 32'h1234_00F0, seen, xy);
			exp = s[2] ? 32'h00F0_1234 : 32'h1234_00F0;
			exp = exp ^ {{16{s[0]}}, {16{s[1]}}};
			chk({31'h0, seen}, 32'h1, "area bypass");
			chk(xy, exp, "orientation");
		end
		posSample(8'h00, 1'b0, 32'h1234_00F0, seen, xy);
		chk({31'h0, seen}, 32'h0, "area reject");
		posSample(8'h00, 1'b1, 32'h1234_00F0, seen, xy);
		chk(xy, 32'h1234_00F0, "area pass");
		// fixed damping: a quarter of the 0x40 step is taken
		posSample(8'h58, 1'b1, 32'h1274_00F0, seen, xy);
		chk(xy, 32'h1244_00F0, "fixed damping step");
		// adaptive damping: a move above 0x40 takes half the step
		posSample(8'h48, 1'b1, 32'h1344_00F0, seen, xy);
		chk(xy, 32'h12C4_00F0, "adaptive damping step");
		// a move inside the jitter band is held
		posSample(8'h60, 1'b1, 32'h12C6_00F0, seen, xy);
		chk(xy, 32'h12C4_00F0, "jitter hold");
	endtask

	task automatic testGest();
		logic [15:0] en;
		for (int i = 0; i < 16; i++) begin
			en = 16'h0001 << i;
			wr(`TSG_IDX_GEST, {16'h0, en});
			@(posedge sys_clk);
			gestureDetect <= 16'hFFFF;
			@(posedge sys_clk);
			gestureDetect <= 16'h0000;
			@(posedge sys_clk);
			chk({16'h0, gestureOut_r}, {16'h0, en & 16'hFF1F}, "gesture gate");
		end
	endtask

	// ****************
	// main sequence
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		reset_n = 1'b0;
		powerMode = TSG_MODE_ACTIVE;
		convStart = 1'b0;
		senseEdge = 1'b0;
		rawPos = '0;
		areaOk = 1'b0;
		gestureDetect = 16'h0000;
		nErrors = 0;
		samplesChecked = 0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		testRegs();
		testConv();
		testPos();
		testGest();
		conclude();
	end
endmodule

/* tsg_pkg.sv */
// types shared by the trackpad config block
package tsg_pkg;
	typedef enum logic [1:0] {
		TSG_MODE_ACTIVE,
		TSG_MODE_LOW_ONE,
		TSG_MODE_LOW_TWO
	} tsg_mode_t;
	typedef struct packed {
		logic [7:0] fraction;
		logic [7:0] periodOne;
		logic [7:0] periodTwo;
	} tsg_freq_t;
	typedef struct packed {
		logic valid;
		logic [15:0] x;
		logic [15:0] y;
	} tsg_pos_t;
endpackage

/* tsg_regs.svh */
// register offsets, field positions, reset values and timing counts of the trackpad config block
`ifndef TSG_REGS_SVH
`define TSG_REGS_SVH
`define TSG_IDX_PAD_FRAC 14'h11D8
`define TSG_IDX_PAD_P1 14'h11D9
`define TSG_IDX_PAD_P2 14'h11DA
`define TSG_IDX_WAKE_FRAC 14'h11DB
`define TSG_IDX_WAKE_P1 14'h11DC
`define TSG_IDX_WAKE_P2 14'h11DD
`define TSG_IDX_PAD_ACQ 14'h11DE
`define TSG_IDX_WAKE_ACQ 14'h11E0
`define TSG_IDX_POS 14'h11E2
`define TSG_IDX_GEST 14'h11F6
`define TSG_IDX_CTRL 14'h1200
`define TSG_IDX_IRQ_STAT 14'h1201
`define TSG_IDX_IRQ_MASK 14'h1202
`define TSG_RST_BYTE 8'h00
`define TSG_RST_WORD 16'h0000
`define TSG_RST_POS 8'h08
`define TSG_POS_MASK 8'h7F
`define TSG_GEST_MASK 16'hFF1F
`define TSG_ACQ_DELAY_HI 15
`define TSG_ACQ_DELAY_LO 14
`define TSG_ACQ_LIMIT_HI 10
`define TSG_ACQ_LIMIT_LO 8
`define TSG_POS_AREA_BYP 6
`define TSG_POS_JITTER 5
`define TSG_POS_FIXED_DAMP 4
`define TSG_POS_IIR 3
`define TSG_POS_AXIS_EXCH 2
`define TSG_POS_FLIP_Y 1
`define TSG_POS_FLIP_X 0
`define TSG_DELAY_C0 12'h010
`define TSG_DELAY_C1 12'h020
`define TSG_DELAY_C2 12'h040
`define TSG_DELAY_C3 12'h100
`define TSG_LIMIT_C0 12'h17F
`define TSG_LIMIT_C1 12'h1FF
`define TSG_LIMIT_C2 12'h2FF
`define TSG_LIMIT_C3 12'h3FF
`define TSG_LIMIT_C4 12'h7FF
`define TSG_JITTER_BAND 16'h0004
`define TSG_IIR_MOVE 16'h0040
`define TSG_IRQ_CONV 0
`define TSG_IRQ_POS 1
`define TSG_IRQ_GEST 2
`endif
